// >>> inc/ltsd_defs.svh
// Constants of the link clock synchronization port: widths, counts and timing.
`ifndef LTSD_DEFS_SVH
`define LTSD_DEFS_SVH

// ==========================================================================
// Widths
// ==========================================================================
`define LTSD_TIME_W        42
`define LTSD_FIELD_W       7
`define LTSD_CHAR_W        8
`define LTSD_RTC_W         32
`define LTSD_RTC_PAD_W     10
`define LTSD_INTERVAL_W    26
`define LTSD_FILL_CNT_W    8
`define LTSD_PRESCALE_W    8

// ==========================================================================
// Field positions inside the 42-bit time value, most significant first
// ==========================================================================
`define LTSD_F1_LSB        35
`define LTSD_F2_LSB        28
`define LTSD_F3_LSB        21
`define LTSD_F4_LSB        14
`define LTSD_F5_LSB        7
`define LTSD_F6_LSB        0

// ==========================================================================
// Timing
// ==========================================================================
`define LTSD_CLK_PERIOD_PS 4000
`define LTSD_US_PS         1000000
`define LTSD_CYC_PER_US    (`LTSD_US_PS / `LTSD_CLK_PERIOD_PS)
`define LTSD_DEF_INTERVAL_US 1000000

// ==========================================================================
// Gap bracketing and addressing
// ==========================================================================
`define LTSD_MIN_FILL_BEFORE 8'h02
`define LTSD_MIN_FILL_AFTER  8'h02
`define LTSD_PRIM_COUNT      8'h03
`define LTSD_SERVER_WKA      24'hFFFFF6

`endif

// >>> inc/ltsd_pkg.sv
// Types shared by the link clock synchronization port.
package ltsd_pkg;

  // ==========================================================================
  // Primitive position within the group of three
  // ==========================================================================
  typedef enum logic [1:0] {
    LTSD_PRIM_FIRST  = 2'h0,
    LTSD_PRIM_SECOND = 2'h1,
    LTSD_PRIM_THIRD  = 2'h2
  } ltsd_prim_t;

  typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_SECOND, TX_THIRD} ltsd_tx_state_t;
  typedef enum logic [1:0] {RX_WAIT, RX_GOT1, RX_GOT2} ltsd_rx_state_t;

endpackage : ltsd_pkg

// >>> inc/ltsd_code_if.sv
// Carrier between the port logic and one neutral-disparity character coder.
`timescale 1ns/1ns
`default_nettype none
interface ltsd_code_if;
  logic [6:0] val;
  logic [7:0] chr;
  logic [7:0] rx_chr;
  logic [6:0] rx_val;
  logic       rx_ok;
  modport user  (output val, output rx_chr, input chr, input rx_val, input rx_ok);
  modport coder (input val, input rx_chr, output chr, output rx_val, output rx_ok);
endinterface : ltsd_code_if
`default_nettype wire

// >>> src/ltsd_nd_code.sv
// Neutral-disparity character coder: 7-bit field to data character and back.
`timescale 1ns/1ns
`default_nettype none
module ltsd_nd_code (
  ltsd_code_if.coder cif // Field and character pair
);

  // ==========================================================================
  // Character table
  // ==========================================================================
  // Row order of the 13-member and 19-member character columns.
  function automatic logic [4:0] row13(input logic [3:0] k);
    case (k)
      4'h0:    row13 = 5'h1F;
      4'h1:    row13 = 5'h1E;
      4'h2:    row13 = 5'h1D;
      4'h3:    row13 = 5'h1B;
      4'h4:    row13 = 5'h18;
      4'h5:    row13 = 5'h17;
      4'h6:    row13 = 5'h10;
      4'h7:    row13 = 5'h0F;
      4'h8:    row13 = 5'h08;
      4'h9:    row13 = 5'h04;
      4'hA:    row13 = 5'h02;
      4'hB:    row13 = 5'h01;
      default: row13 = 5'h00;
    endcase
  endfunction : row13

  function automatic logic [4:0] row19(input logic [4:0] k);
    case (k)
      5'h00:   row19 = 5'h1C;
      5'h01:   row19 = 5'h1A;
      5'h02:   row19 = 5'h19;
      5'h03:   row19 = 5'h16;
      5'h04:   row19 = 5'h15;
      5'h05:   row19 = 5'h14;
      5'h06:   row19 = 5'h13;
      5'h07:   row19 = 5'h12;
      5'h08:   row19 = 5'h11;
      5'h09:   row19 = 5'h0E;
      5'h0A:   row19 = 5'h0D;
      5'h0B:   row19 = 5'h0C;
      5'h0C:   row19 = 5'h0B;
      5'h0D:   row19 = 5'h0A;
      5'h0E:   row19 = 5'h09;
      5'h0F:   row19 = 5'h07;
      5'h10:   row19 = 5'h06;
      5'h11:   row19 = 5'h05;
      default: row19 = 5'h03;
    endcase
  endfunction : row19

  // The character's decimal index equals the field value; result is {y, xx}.
  function automatic logic [7:0] enc(input logic [6:0] v);
    logic [2:0] y;
    logic [4:0] x;
    y = 3'h7;
    x = row13(4'h0);
    if (v < 7'h06)
    begin
      y = 3'h7;
      x = row13(4'(v + 7'h07));
    end
    else if (v < 7'h19)
    begin
      y = 3'h6;
      x = row19(5'(v - 7'h06));
    end
    else if (v < 7'h2C)
    begin
      y = 3'h5;
      x = row19(5'(v - 7'h19));
    end
    else if (v < 7'h39)
    begin
      y = 3'h4;
      x = row13(4'(v - 7'h2C));
    end
    else if (v < 7'h4C)
    begin
      y = 3'h3;
      x = row19(5'(v - 7'h39));
    end
    else if (v < 7'h5F)
    begin
      y = 3'h2;
      x = row19(5'(v - 7'h4C));
    end
    else if (v < 7'h72)
    begin
      y = 3'h1;
      x = row19(5'(v - 7'h5F));
    end
    else if (v < 7'h7F)
    begin
      y = 3'h0;
      x = row13(4'(v - 7'h72));
    end
    enc = {y, x};
  endfunction : enc

  // ==========================================================================
  // Encode and decode
  // ==========================================================================
  assign cif.chr = enc(cif.val); // RQ18

  // Characters outside the table decode as invalid, except 8'hFF, which decodes as 127.
  always_comb
  begin
    cif.rx_val = 7'h00;
    cif.rx_ok  = 1'b0;
    for (int i = 0; i < 128; i++)
    begin
      if (enc(7'(i)) == cif.rx_chr) // RQ18
      begin
        cif.rx_val = 7'(i);
        cif.rx_ok  = 1'b1;
      end
    end
  end

endmodule : ltsd_nd_code
`default_nettype wire

// >>> src/ltsd_port.sv
// Fabric port with clock synchronization event source, relay and receive.
// Function
// RQ1 - Periodic events or disabled.
// RQ2 - Interval defaults to one second.
// RQ3 - Interval in microseconds, zero allowed.
// RQ4 - Narrow clock zero-extended to 42 bits.
// RQ5 - Characters derived from the 42-bit value.
// RQ6 - Server answers at fixed well-known address.
// RQ7 - Exactly one port is the server port.
// RQ8 - Ports accept primitives repeatedly.
// RQ9 - Non-server ports treat primitives as fill.
// RQ10 - Other ports transmit primitives after server receipt.
// RQ11 - Sent value matches server clock closely.
// RQ12 - Unsupporting clients ignore or treat as fill.
// RQ13 - Supporting clients accept repeatedly, keep clock.
// RQ14 - Clients load after three consecutive primitives.
// RQ15 - Three fills replaced, two fills bracketing.
// RQ16 - Each primitive carries two 7-bit fields.
// RQ17 - Six fields form value, most significant first.
// RQ18 - Field maps to neutral-disparity character index.
// RQ19 - Zero interval issues no events.
// RQ20 - Counter restarts on each event.
`include "ltsd_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module ltsd_port #(
  parameter logic [`LTSD_INTERVAL_W-1:0] DEF_INTERVAL_US = `LTSD_INTERVAL_W'(`LTSD_DEF_INTERVAL_US)
) (
  input  wire logic                          clk,               // Core clock, 250 MHz
  input  wire logic                          reset_n,           // Asynchronous reset
  input  wire logic                          server_port_strap, // Port faces the server
  output logic                               is_server_port,    // Captured role
  output logic [23:0]                        server_wka,        // Server address
  input  wire logic                          sync_enable,       // Periodic events on
  input  wire logic [`LTSD_INTERVAL_W-1:0]   interval_us,       // New interval
  input  wire logic                          interval_wr,       // Load interval
  input  wire logic [`LTSD_RTC_W-1:0]        rtc_value,         // Local clock
  input  wire logic                          relay_req,         // Server port got time
  input  wire logic                          tx_fill_slot,      // Slot carries a fill
  input  wire logic [`LTSD_FILL_CNT_W-1:0]   tx_fills_left,     // Fills left in gap
  output logic                               tx_prim_valid,     // Substitute slot
  output ltsd_pkg::ltsd_prim_t               tx_prim_kind,      // Primitive position
  output logic [7:0]                         tx_char_hi,        // First character
  output logic [7:0]                         tx_char_lo,        // Second character
  input  wire logic                          rx_word_valid,     // Word received
  input  wire logic                          rx_prim_valid,     // Word is a primitive
  input  wire ltsd_pkg::ltsd_prim_t          rx_prim_kind,      // Primitive position
  input  wire logic [7:0]                    rx_char_hi,        // First character
  input  wire logic [7:0]                    rx_char_lo,        // Second character
  output logic                               rx_as_fill,        // Handle as fill
  output logic [`LTSD_TIME_W-1:0]            rx_time,           // Received time
  output logic                               rx_time_valid      // Received time pulse
);
  import ltsd_pkg::*;

  localparam logic [`LTSD_PRESCALE_W-1:0] PRESCALE_LAST = `LTSD_PRESCALE_W'(`LTSD_CYC_PER_US - 1);

  // ==========================================================================
  // Coders
  // ==========================================================================
  ltsd_code_if cif_hi ();
  ltsd_code_if cif_lo ();
  ltsd_nd_code u_code_hi (.cif(cif_hi));
  ltsd_nd_code u_code_lo (.cif(cif_lo));

  assign server_wka = `LTSD_SERVER_WKA; // RQ6

  // ==========================================================================
  // Role capture and event timer
  // ==========================================================================
  logic                        role_done_ff, nxt_role_done;
  logic                        server_ff, nxt_server;
  logic [`LTSD_INTERVAL_W-1:0] interval_ff, nxt_interval;
  logic [`LTSD_INTERVAL_W-1:0] cnt_ff, nxt_cnt;
  logic [`LTSD_PRESCALE_W-1:0] pre_ff, nxt_pre;
  logic                        pend_ff, nxt_pend;
  logic                        tmr_evt;
  logic                        tx_start;

  always_comb
  begin
    nxt_role_done = 1'b1;
    nxt_server    = role_done_ff ? server_ff : server_port_strap; // RQ7
    nxt_interval  = interval_wr ? interval_us : interval_ff; // RQ3
    nxt_pre       = (pre_ff == PRESCALE_LAST) ? '0 : pre_ff + 1'b1;
    nxt_cnt       = cnt_ff;
    tmr_evt       = 1'b0;
    if (interval_wr || !sync_enable)
    begin
      nxt_cnt = '0;
    end
    else if (interval_ff != '0 && pre_ff == PRESCALE_LAST) // RQ19
    begin
      if (cnt_ff + 1'b1 >= interval_ff) // RQ1
      begin
        tmr_evt = 1'b1;
        nxt_cnt = '0; // RQ20
      end
      else
      begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
    // A new request arriving as the pending one is taken stays pending.
    nxt_pend = (tmr_evt || (relay_req && !server_ff)) ? 1'b1 : (tx_start ? 1'b0 : pend_ff); // RQ10
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      role_done_ff <= 1'b0;
      server_ff    <= 1'b0;
      interval_ff  <= DEF_INTERVAL_US; // RQ2
      cnt_ff       <= '0;
      pre_ff       <= '0;
      pend_ff      <= 1'b0;
    end
    else
    begin
      role_done_ff <= nxt_role_done;
      server_ff    <= nxt_server;
      interval_ff  <= nxt_interval;
      cnt_ff       <= nxt_cnt;
      pre_ff       <= nxt_pre;
      pend_ff      <= nxt_pend;
    end
  end

  assign is_server_port = server_ff;

  // ==========================================================================
  // Transmit substitution
  // ==========================================================================
  ltsd_tx_state_t              tx_st_ff, nxt_tx_st;
  logic [`LTSD_FILL_CNT_W-1:0] fills_ff, nxt_fills;
  logic [`LTSD_TIME_W-1:0]     tx_time_ff, nxt_tx_time;
  logic [7:0]                  hi_ff, nxt_hi, lo_ff, nxt_lo;

  // Start only where two fills precede and three plus two fills remain.
  assign tx_start = (tx_st_ff == TX_IDLE) && pend_ff && !server_ff && tx_fill_slot
                 && (fills_ff >= `LTSD_MIN_FILL_BEFORE - 8'h01)
                 && (tx_fills_left >= `LTSD_PRIM_COUNT + `LTSD_MIN_FILL_AFTER + 1'b1); // RQ15

  always_comb
  begin
    nxt_fills   = tx_fill_slot ? fills_ff + 1'b1 : '0;
    if (tx_fill_slot && fills_ff == '1)
    begin
      nxt_fills = fills_ff;
    end
    nxt_tx_time = tx_time_ff;
    nxt_tx_st   = tx_st_ff;
    cif_hi.val  = tx_time_ff[`LTSD_F3_LSB +: `LTSD_FIELD_W];
    cif_lo.val  = tx_time_ff[`LTSD_F4_LSB +: `LTSD_FIELD_W];
    case (tx_st_ff)
      TX_IDLE:
      begin
        if (tx_start)
        begin
          nxt_tx_time = {`LTSD_RTC_PAD_W'(0), rtc_value}; // RQ4 RQ11
          nxt_tx_st   = TX_FIRST; // RQ15
          cif_hi.val  = nxt_tx_time[`LTSD_F1_LSB +: `LTSD_FIELD_W]; // RQ17
          cif_lo.val  = nxt_tx_time[`LTSD_F2_LSB +: `LTSD_FIELD_W];
        end
      end
      TX_FIRST:  nxt_tx_st = TX_SECOND;
      TX_SECOND:
      begin
        nxt_tx_st  = TX_THIRD;
        cif_hi.val = tx_time_ff[`LTSD_F5_LSB +: `LTSD_FIELD_W];
        cif_lo.val = tx_time_ff[`LTSD_F6_LSB +: `LTSD_FIELD_W];
      end
      TX_THIRD:  nxt_tx_st = TX_IDLE;
      default:   nxt_tx_st = TX_IDLE;
    endcase
    nxt_hi = cif_hi.chr; // RQ5 RQ16
    nxt_lo = cif_lo.chr;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_st_ff   <= TX_IDLE;
      fills_ff   <= '0;
      tx_time_ff <= '0;
      hi_ff      <= 8'h00;
      lo_ff      <= 8'h00;
    end
    else
    begin
      tx_st_ff   <= nxt_tx_st;
      fills_ff   <= nxt_fills;
      tx_time_ff <= nxt_tx_time;
      hi_ff      <= nxt_hi;
      lo_ff      <= nxt_lo;
    end
  end

  assign tx_prim_valid = (tx_st_ff != TX_IDLE);
  assign tx_prim_kind  = (tx_st_ff == TX_THIRD) ? LTSD_PRIM_THIRD :
                         (tx_st_ff == TX_SECOND) ? LTSD_PRIM_SECOND : LTSD_PRIM_FIRST;
  assign tx_char_hi    = hi_ff;
  assign tx_char_lo    = lo_ff;

  // ==========================================================================
  // Receive collection
  // ==========================================================================
  ltsd_rx_state_t          rx_st_ff, nxt_rx_st;
  logic [27:0]             acc_ff, nxt_acc;
  logic [`LTSD_TIME_W-1:0] rx_time_ff, nxt_rx_time;
  logic                    rx_tv_ff, nxt_rx_tv;
  logic                    fill_ff, nxt_fill;
  logic                    rx_good;

  assign cif_hi.rx_chr = rx_char_hi;
  assign cif_lo.rx_chr = rx_char_lo;
  assign rx_good       = rx_word_valid && rx_prim_valid && cif_hi.rx_ok && cif_lo.rx_ok;

  always_comb
  begin
    nxt_fill    = rx_word_valid && rx_prim_valid && !server_ff; // RQ9
    nxt_rx_tv   = 1'b0;
    nxt_rx_time = rx_time_ff;
    nxt_acc     = acc_ff;
    nxt_rx_st   = rx_st_ff;
    if (rx_word_valid)
    begin
      // Any word that breaks the group of three restarts collection.
      nxt_rx_st = RX_WAIT;
      if (rx_good && server_ff && rx_prim_kind == LTSD_PRIM_FIRST) // RQ8
      begin
        nxt_acc[27:14] = {cif_hi.rx_val, cif_lo.rx_val}; // RQ17
        nxt_rx_st      = RX_GOT1;
      end
      else if (rx_good && server_ff)
      begin
        case (rx_st_ff)
          RX_GOT1:
          begin
            if (rx_prim_kind == LTSD_PRIM_SECOND)
            begin
              nxt_acc[13:0] = {cif_hi.rx_val, cif_lo.rx_val};
              nxt_rx_st     = RX_GOT2;
            end
          end
          RX_GOT2:
          begin
            if (rx_prim_kind == LTSD_PRIM_THIRD)
            begin
              nxt_rx_time = {acc_ff, cif_hi.rx_val, cif_lo.rx_val}; // RQ17
              nxt_rx_tv   = 1'b1; // RQ10
            end
          end
          default: nxt_rx_st = RX_WAIT;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_st_ff   <= RX_WAIT;
      acc_ff     <= '0;
      rx_time_ff <= '0;
      rx_tv_ff   <= 1'b0;
      fill_ff    <= 1'b0;
    end
    else
    begin
      rx_st_ff   <= nxt_rx_st;
      acc_ff     <= nxt_acc;
      rx_time_ff <= nxt_rx_time;
      rx_tv_ff   <= nxt_rx_tv;
      fill_ff    <= nxt_fill;
    end
  end

  assign rx_as_fill    = fill_ff;
  assign rx_time       = rx_time_ff;
  assign rx_time_valid = rx_tv_ff;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_zero_quiet;
    @(posedge clk) disable iff (!reset_n) (interval_ff == '0) |-> !tmr_evt;
  endproperty
  a_zero_quiet: assert property (p_zero_quiet) else $error("event with zero interval"); // RQ19

  property p_evt_enabled;
    @(posedge clk) disable iff (!reset_n) tmr_evt |-> sync_enable && pre_ff == PRESCALE_LAST;
  endproperty
  a_evt_enabled: assert property (p_evt_enabled) else $error("event while disabled"); // RQ1

  property p_default_interval;
    @(posedge clk) disable iff (!reset_n) !$past(reset_n) |-> interval_ff == DEF_INTERVAL_US;
  endproperty
  a_default_interval: assert property (p_default_interval) else $error("bad default"); // RQ2

  property p_restart;
    @(posedge clk) disable iff (!reset_n) tmr_evt |=> cnt_ff == '0 && pend_ff;
  endproperty
  a_restart: assert property (p_restart) else $error("counter not restarted"); // RQ20

  property p_three_prims;
    @(posedge clk) disable iff (!reset_n) tx_start |=> tx_prim_kind == LTSD_PRIM_FIRST
      ##1 tx_prim_kind == LTSD_PRIM_SECOND ##1 tx_prim_kind == LTSD_PRIM_THIRD
      ##1 !tx_prim_valid;
  endproperty
  a_three_prims: assert property (p_three_prims) else $error("bad primitive group"); // RQ15

  property p_bracket;
    @(posedge clk) disable iff (!reset_n) $rose(tx_prim_valid) |->
      $past(fills_ff) >= 8'h01 && $past(tx_fills_left) >= 8'h06;
  endproperty
  a_bracket: assert property (p_bracket) else $error("fills not bracketing"); // RQ15

  property p_server_silent;
    @(posedge clk) disable iff (!reset_n) server_ff |=> !tx_prim_valid || $past(tx_prim_valid);
  endproperty
  a_server_silent: assert property (p_server_silent) else $error("server port sent"); // RQ10

  property p_pad;
    @(posedge clk) disable iff (!reset_n) tx_start |=> tx_time_ff[41:32] == 10'h000
      && tx_time_ff[31:0] == $past(rtc_value);
  endproperty
  a_pad: assert property (p_pad) else $error("time not zero-extended"); // RQ4

  property p_as_fill;
    @(posedge clk) disable iff (!reset_n)
      rx_word_valid && rx_prim_valid && !server_ff |=> rx_as_fill && !rx_time_valid;
  endproperty
  a_as_fill: assert property (p_as_fill) else $error("primitive not taken as fill"); // RQ9

  property p_rx_load;
    @(posedge clk) disable iff (!reset_n) rx_time_valid |->
      $past(rx_st_ff) == RX_GOT2 && $past(rx_prim_kind) == LTSD_PRIM_THIRD && server_ff;
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("time loaded out of order"); // RQ17

  c_tx_group: cover property (@(posedge clk) disable iff (!reset_n) tx_start ##3 tx_prim_valid);
  c_rx_load:  cover property (@(posedge clk) disable iff (!reset_n) rx_time_valid);
  c_tmr_evt:  cover property (@(posedge clk) disable iff (!reset_n) tmr_evt);

endmodule : ltsd_port
`default_nettype wire

// >>> dv/ltsd_partner.sv
// Link partner that sends time primitives and fill words to the port.
`timescale 1ns/1ns
`default_nettype none
module ltsd_partner (
  input  wire logic                clk,    // Core clock
  output logic                     word_v, // Word on the link
  output logic                     prim_v, // Word is a primitive
  output var ltsd_pkg::ltsd_prim_t kind,   // Primitive position
  output logic [7:0]               hi,     // First character
  output logic [7:0]               lo      // Second character
);
  import ltsd_pkg::*;

  initial
  begin
    word_v = 1'b0;
    prim_v = 1'b0;
    kind   = LTSD_PRIM_FIRST;
    hi     = 8'h00;
    lo     = 8'h00;
  end

  // ==========================================================================
  // Encoding and transfers
  // ==========================================================================
  function automatic logic [7:0] nd_char(input logic [6:0] v);
    int a[13] = '{0, 1, 2, 4, 8, 15, 16, 23, 24, 27, 29, 30, 31};
    int b[19] = '{3, 5, 6, 7, 9, 10, 11, 12, 13, 14, 17, 18, 19, 20, 21, 22, 25, 26, 28};
    int i = v;
    if (i <= 5) return {3'h7, 5'(a[5 - i])};
    if (i <= 24) return {3'h6, 5'(b[24 - i])};
    if (i <= 43) return {3'h5, 5'(b[43 - i])};
    if (i <= 56) return {3'h4, 5'(a[56 - i])};
    if (i <= 75) return {3'h3, 5'(b[75 - i])};
    if (i <= 94) return {3'h2, 5'(b[94 - i])};
    if (i <= 113) return {3'h1, 5'(b[113 - i])};
    if (i <= 126) return {3'h0, 5'(a[126 - i])};
    return 8'hFF;
  endfunction : nd_char

  task automatic put(input logic p, input logic [1:0] k, input logic [6:0] f1, input logic [6:0] f0);
    word_v = 1'b1;
    prim_v = p;
    kind   = ltsd_prim_t'(k);
    hi     = nd_char(f1);
    lo     = nd_char(f0);
    @(negedge clk);
  endtask : put

  // Released characters are inverted so that a stale value cannot pass.
  task automatic idle();
    word_v = 1'b0;
    prim_v = 1'b0;
    hi     = ~hi;
    lo     = ~lo;
    @(negedge clk);
  endtask : idle

  task automatic send_time(input logic [41:0] t, input logic gap);
    for (int i = 0; i < 3; i++)
    begin
      put(1'b1, 2'(i), t[41 - 14 * i -: 7], t[34 - 14 * i -: 7]);
      if (gap && i == 1) put(1'b0, 2'h0, 7'h00, 7'h00);
    end
    idle();
    idle();
  endtask : send_time
endmodule : ltsd_partner
`default_nettype wire

// >>> dv/ltsd_port_bench.sv
// Self-checking bench for the clock synchronization port.
`timescale 1ns/1ns
`default_nettype none
module ltsd_port_bench;
  import ltsd_pkg::*;
  localparam int US = 250;
  logic        clk, reset_n, strap, sync_en, iv_wr, relay, fill, wv, pv, tpv, tv, afill, srv;
  logic [25:0] iv;
  logic [31:0] rtc;
  logic [7:0]  left, thi, tlo, rhi, rlo;
  logic [41:0] rtime, v;
  logic [23:0] wka;
  ltsd_prim_t  tk, rk;
  logic [15:0] lfsr_ff;
  logic [17:0] got_q[$];
  int          err_count, n_checks, cyc, n_time, n_fill, w, nt, nf, cl_run, cl_loads;

  ltsd_port #(.DEF_INTERVAL_US(26'h0000003)) u_dut (
    .clk(clk), .reset_n(reset_n), .server_port_strap(strap), .is_server_port(srv),
    .server_wka(wka), .sync_enable(sync_en), .interval_us(iv), .interval_wr(iv_wr),
    .rtc_value(rtc), .relay_req(relay), .tx_fill_slot(fill), .tx_fills_left(left),
    .tx_prim_valid(tpv), .tx_prim_kind(tk), .tx_char_hi(thi), .tx_char_lo(tlo),
    .rx_word_valid(wv), .rx_prim_valid(pv), .rx_prim_kind(rk), .rx_char_hi(rhi),
    .rx_char_lo(rlo), .rx_as_fill(afill), .rx_time(rtime), .rx_time_valid(tv));
  ltsd_partner u_p (.clk(clk), .word_v(wv), .prim_v(pv), .kind(rk), .hi(rhi), .lo(rlo));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Monitors and helpers
  // ==========================================================================
  // Client side: keeps every primitive, ignores broken runs, loads after three in order.
  always @(negedge clk)
  begin
    if (tpv === 1'b1) got_q.push_back({tk, thi, tlo});
    cl_run = (tpv === 1'b1 && int'(tk) == cl_run) ? cl_run + 1 : 0;
    if (cl_run == 3) cl_loads++;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    n_time <= n_time + int'(tv === 1'b1);
    n_fill <= n_fill + int'(afill === 1'b1);
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask : chk

  function automatic logic [15:0] rnd();
    lfsr_ff = (lfsr_ff >> 1) ^ (lfsr_ff[0] ? 16'hB400 : 16'h0000);
    return lfsr_ff;
  endfunction : rnd

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic do_reset(input logic s);
    reset_n = 1'b0;
    strap   = s;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : do_reset

  task automatic set_iv(input logic [25:0] x);
    iv    = x;
    iv_wr = 1'b1;
    @(negedge clk);
    iv_wr = 1'b0;
  endtask : set_iv

  task automatic pulse();
    relay = 1'b1;
    @(negedge clk);
    relay = 1'b0;
  endtask : pulse

  task automatic quiet(input int n);
    got_q.delete();
    repeat (n) @(negedge clk);
    chk(got_q.size(), 0);
  endtask : quiet

  // Waits for one group and compares it with the time expected from rtc.
  task automatic group(input int lo_w, input int hi_w);
    logic [41:0] e;
    logic [17:0] g;
    int          nl;
    nl = cl_loads;
    e = {10'h000, rtc};
    w = 0;
    while (got_q.size() < 3 && w < hi_w)
    begin
      @(negedge clk);
      w++;
    end
    chk(w >= lo_w && w < hi_w, 1'b1);
    chk(cl_loads - nl, 1);
    for (int k = 0; k < 3; k++)
    begin
      g = got_q.size() > 0 ? got_q.pop_front() : 18'h00000;
      chk(g, {2'(k), u_p.nd_char(e[41 - 14 * k -: 7]), u_p.nd_char(e[34 - 14 * k -: 7])});
    end
    rtc = {rnd(), rnd()};
  endtask : group

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    sync_en = 1'b0;
    iv_wr   = 1'b0;
    relay   = 1'b0;
    fill    = 1'b0;
    iv      = 26'h0000000;
    left    = 8'h10;
    lfsr_ff = 16'h45D0;
    rtc     = {rnd(), rnd()};
    do_reset(1'b0);
    chk(wka, 24'hFFFFF6);
    chk(srv, 1'b0);
    sync_en = 1'b1;
    fill    = 1'b1;
    group(3 * US - 20, 3 * US + 20);
    set_iv(26'h0000001);
    repeat (3) group(0, US + 10);
    left = 8'h05;
    quiet(US + 50);
    left = 8'h10;
    group(0, 10);
    set_iv(26'h0000000);
    quiet(3 * US);
    sync_en = 1'b0;
    set_iv(26'h0000001);
    pulse();
    group(0, 10);
    quiet(3 * US);
    nf = n_fill;
    v  = 42'({rnd(), rnd(), rnd()});
    u_p.send_time(v, 1'b0);
    chk(n_fill - nf, 3);
    chk(n_time, 0);
    do_reset(1'b1);
    chk(srv, 1'b1);
    repeat (2)
    begin
      v  = 42'({rnd(), rnd(), rnd()});
      nt = n_time;
      u_p.send_time(v, 1'b0);
      chk(n_time - nt, 1);
      chk(rtime, v);
    end
    nt = n_time;
    u_p.send_time(~v, 1'b1);
    chk(n_time - nt, 0);
    chk(rtime, v);
    chk(n_fill - nf, 3);
    sync_en = 1'b1;
    set_iv(26'h0000001);
    pulse();
    quiet(3 * US);
    print_verdict();
  end
endmodule : ltsd_port_bench
`default_nettype wire
